/* logic/ssp_dev.sv */
// Function
// - Eight-bit shifter, MSb out, LSb in
// - Drive on active edge, sample opposite
// - Master out to slave in, and back
// - Master makes clock; same idle polarity
// - First bit lands in slave LSb
// - Eight bits swap both registers
// - Master stops clock, then deselects slave
// - Unselected slave ignores bus, drives nothing
// - One select per slave, one active
// - Full byte goes to buffer, flag set; dropped if buffer unread and BOEN clear
// - Buffer write also loads shifter
// - Shifter reached only through buffer
// - Status: low six read-only, top two writable
// - First control register fully read-write
// - Reload register sets one master rate
// - Write during transfer ignored, collision flag
// - Buffer-full set when a received byte is stored, cleared on read
// - Master starts clocking on buffer write
// - Rates: /4, /16, /64, timer/2, reload
`timescale 1ns/100ps
module ssp_dev
  import ssp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  ssp_if.dev link,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic irq_flag_clr,
  output logic serial_port_irq_flag,
  input wire logic timer2_tick
);
  ssp_state_e state_q;
  logic [7:0] serial_shift_reg_q;
  logic [7:0] serial_buffer_reg_q;
  logic [7:0] baud_reload_reg_q;
  logic smp_q;
  logic cke_q;
  logic buffer_full_flag_q;
  logic write_collision_flag_q;
  logic ov_q;
  logic en_q;
  logic ckp_q;
  logic [3:0] mode_q;
  logic boen_q;
  logic [2:0] bit_cnt_q;
  logic [3:0] edge_cnt_q;
  logic [9:0] div_cnt_q;
  logic [9:0] half;
  logic sck_q;
  logic sdo_q;
  logic ss_n_q;
  logic sck_oe_n_q;
  logic sdo_oe_n_q;
  logic sck_prev_q;
  logic is_master;
  logic s_sel;
  logic ss_rst;
  logic tick;
  logic sample_ev;
  logic drive_ev;
  logic done;
  logic busy;
  logic buf_wr;
  logic load;
  logic collide;
  logic store;
  logic ctl1_wr;

  assign is_master = (mode_q <= MODE_M_TMR2) || (mode_q == MODE_M_BAUD);
  assign ss_rst = (mode_q == MODE_S_SS) && link.ss_n;
  assign s_sel = en_q && ((mode_q == MODE_S_NOSS) || (mode_q == MODE_S_SS && !link.ss_n));

  always_comb begin
    case (mode_q)
      MODE_M_DIV16: half = HALF_DIV16;
      MODE_M_DIV64: half = HALF_DIV64;
      MODE_M_BAUD: half = {1'b0, baud_reload_reg_q, 1'b0} + HALF_BAUD_ADD;
      default: half = HALF_DIV4;
    endcase
  end

  // Timer-driven rate toggles the clock on every timer pulse, giving half its rate
  assign tick = (state_q == SSP_SHIFT) && ((mode_q == MODE_M_TMR2) ? timer2_tick
                : (div_cnt_q == half - 10'h001));
  always_comb begin
    if (is_master) begin
      sample_ev = tick && (edge_cnt_q[0] != cke_q);
      drive_ev = tick && (edge_cnt_q[0] == cke_q);
    end else if (cke_q) begin
      sample_ev = s_sel && ssp_lead(sck_prev_q, link.sck, ckp_q);
      drive_ev = s_sel && ssp_trail(sck_prev_q, link.sck, ckp_q);
    end else begin
      sample_ev = s_sel && ssp_trail(sck_prev_q, link.sck, ckp_q);
      drive_ev = s_sel && ssp_lead(sck_prev_q, link.sck, ckp_q);
    end
  end

  assign done = sample_ev && (bit_cnt_q == LAST_BIT);
  assign busy = is_master ? (state_q != SSP_IDLE) : (bit_cnt_q != 3'h0);
  assign buf_wr = reg_wr && (reg_addr == REG_BUF);
  assign collide = buf_wr && busy;
  assign load = buf_wr && !busy && !write_collision_flag_q;
  // Without BOEN an unread byte is kept and the new one is dropped as overflow
  assign store = done && (!buffer_full_flag_q || boen_q);
  assign ctl1_wr = reg_wr && (reg_addr == REG_CTL1);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      smp_q <= 1'b0;
      cke_q <= 1'b0;
      en_q <= 1'b0;
      ckp_q <= 1'b0;
      mode_q <= MODE_M_DIV4;
      boen_q <= 1'b0;
      baud_reload_reg_q <= RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_STAT: {smp_q, cke_q} <= reg_wdata[STAT_SMP:STAT_CKE];
        REG_CTL1: begin
          en_q <= reg_wdata[CTL1_EN];
          ckp_q <= reg_wdata[CTL1_CKP];
          mode_q <= reg_wdata[3:0];
        end
        REG_CTL3: boen_q <= reg_wdata[CTL3_BOEN];
        REG_BAUD: baud_reload_reg_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      write_collision_flag_q <= 1'b0;
      ov_q <= 1'b0;
      buffer_full_flag_q <= 1'b0;
      serial_port_irq_flag <= 1'b0;
    end else begin
      if (collide) begin
        write_collision_flag_q <= 1'b1;
      end else if (ctl1_wr) begin
        write_collision_flag_q <= reg_wdata[CTL1_WRITE_COLLISION_FLAG];
      end
      if (done && buffer_full_flag_q && !boen_q) begin
        ov_q <= 1'b1;
      end else if (ctl1_wr) begin
        ov_q <= reg_wdata[CTL1_OV];
      end
      if (store) begin
        buffer_full_flag_q <= 1'b1;
      end else if (reg_rd && reg_addr == REG_BUF) begin
        buffer_full_flag_q <= 1'b0;
      end
      if (done) begin
        serial_port_irq_flag <= 1'b1;
      end else if (irq_flag_clr) begin
        serial_port_irq_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      serial_buffer_reg_q <= RST_BYTE;
      serial_shift_reg_q <= RST_BYTE;
      sdo_q <= 1'b0;
    end else if (load) begin
      serial_buffer_reg_q <= reg_wdata;
      serial_shift_reg_q <= reg_wdata;
      sdo_q <= reg_wdata[7];
    end else begin
      if (sample_ev) begin
        serial_shift_reg_q <= {serial_shift_reg_q[6:0], link.dev_sdi};
      end
      if (store) begin
        serial_buffer_reg_q <= {serial_shift_reg_q[6:0], link.dev_sdi};
      end
      if (drive_ev) begin
        sdo_q <= serial_shift_reg_q[7];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q <= 3'h0;
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= link.sck;
      if (!en_q || ss_rst) begin
        bit_cnt_q <= 3'h0;
      end else if (sample_ev) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SSP_IDLE;
      edge_cnt_q <= 4'h0;
      div_cnt_q <= 10'h000;
      sck_q <= 1'b0;
      ss_n_q <= 1'b1;
    end else begin
      case (state_q)
        SSP_IDLE: begin
          sck_q <= ckp_q;
          edge_cnt_q <= 4'h0;
          div_cnt_q <= 10'h000;
          ss_n_q <= 1'b1;
          if (load && en_q && is_master) begin
            state_q <= SSP_SHIFT;
            ss_n_q <= 1'b0;
          end
        end
        SSP_SHIFT: begin
          div_cnt_q <= tick ? 10'h000 : div_cnt_q + 10'h001;
          if (!en_q || !is_master) begin
            state_q <= SSP_IDLE;
          end else if (tick) begin
            sck_q <= ~sck_q;
            edge_cnt_q <= edge_cnt_q + 4'h1;
            if (edge_cnt_q == LAST_EDGE) begin
              state_q <= SSP_IDLE;
            end
          end
        end
        default: state_q <= SSP_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sck_oe_n_q <= 1'b1;
      sdo_oe_n_q <= 1'b1;
    end else begin
      sck_oe_n_q <= !(en_q && is_master);
      sdo_oe_n_q <= !((en_q && is_master) || s_sel);
    end
  end

  // Reads are registered; a buffer read is the only access with a side effect
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_BUF: reg_rdata <= serial_buffer_reg_q;
        REG_STAT: reg_rdata <= {smp_q, cke_q, 5'h00, buffer_full_flag_q};
        REG_CTL1: reg_rdata <= {write_collision_flag_q, ov_q, en_q, ckp_q, mode_q};
        REG_CTL3: reg_rdata <= {3'h0, boen_q, 4'h0};
        REG_BAUD: reg_rdata <= baud_reload_reg_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  assign link.dev_sck_o = sck_q;
  assign link.dev_sck_oe_n = sck_oe_n_q;
  assign link.dev_sdo_o = sdo_q;
  assign link.dev_sdo_oe_n = sdo_oe_n_q;
  assign link.dev_ss_n_o = ss_n_q;
  assign link.dev_ss_oe_n = sck_oe_n_q;
endmodule : ssp_dev

/* logic/ssp_far.sv */
`timescale 1ns/100ps
module ssp_far
  import ssp_pkg::*;
#(
  parameter logic [9:0] HALF = 10'h008,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  ssp_if.far link,
  input wire logic cfg_master,
  input wire logic cfg_cpol,
  input wire logic cfg_cke,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic busy
);
  ssp_state_e state_q;
  logic [7:0] sr_q;
  logic [2:0] bit_cnt_q;
  logic [3:0] edge_cnt_q;
  logic [9:0] div_cnt_q;
  logic sck_q;
  logic sdo_q;
  logic ss_n_q;
  logic sck_prev_q;
  logic armed_q;
  logic f_valid;
  logic [7:0] f_data;
  logic f_pop;
  logic tick;
  logic s_sel;
  logic s_lead;
  logic s_trail;
  logic sample_ev;
  logic drive_ev;
  logic done;
  logic m_load;
  logic s_load;

  // Bytes queue here so the user side can run ahead of the serial link
  ssp_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(tx_valid),
    .in_data(tx_data),
    .in_ready(tx_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_pop)
  );

  assign tick = (state_q == SSP_SHIFT) && (div_cnt_q == HALF - 10'h001);
  assign s_sel = !cfg_master && !link.ss_n;
  assign s_lead = s_sel && ssp_lead(sck_prev_q, link.sck, cfg_cpol);
  assign s_trail = s_sel && ssp_trail(sck_prev_q, link.sck, cfg_cpol);
  assign sample_ev = cfg_master ? tick && (edge_cnt_q[0] != cfg_cke)
                                : (cfg_cke ? s_lead : s_trail);
  assign drive_ev = cfg_master ? tick && (edge_cnt_q[0] == cfg_cke)
                               : (cfg_cke ? s_trail : s_lead);
  assign done = sample_ev && (bit_cnt_q == LAST_BIT);
  // Master reloads from the queue on the last edge; idle master starts a frame
  assign m_load = cfg_master && f_valid &&
                  ((state_q == SSP_IDLE) || (tick && edge_cnt_q == LAST_EDGE));
  assign s_load = s_sel && !armed_q && (bit_cnt_q == 3'h0) && !sample_ev;
  assign f_pop = m_load || (s_load && f_valid);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SSP_IDLE;
      edge_cnt_q <= 4'h0;
      div_cnt_q <= 10'h000;
      sck_q <= 1'b0;
      ss_n_q <= 1'b1;
    end else if (!cfg_master) begin
      state_q <= SSP_IDLE;
      sck_q <= cfg_cpol;
      ss_n_q <= 1'b1;
    end else begin
      case (state_q)
        SSP_IDLE: begin
          sck_q <= cfg_cpol;
          div_cnt_q <= 10'h000;
          edge_cnt_q <= 4'h0;
          if (m_load) begin
            state_q <= SSP_SHIFT;
            ss_n_q <= 1'b0;
          end
        end
        SSP_SHIFT: begin
          div_cnt_q <= tick ? 10'h000 : div_cnt_q + 10'h001;
          if (tick) begin
            sck_q <= ~sck_q;
            edge_cnt_q <= edge_cnt_q + 4'h1;
            if (edge_cnt_q == LAST_EDGE && !m_load) begin
              state_q <= SSP_IDLE;
              ss_n_q <= 1'b1;
            end
          end
        end
        default: state_q <= SSP_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sr_q <= RST_BYTE;
      sdo_q <= 1'b0;
    end else if (f_pop) begin
      sr_q <= f_data;
      sdo_q <= f_data[7];
    end else if (s_load) begin
      sr_q <= FILL_BYTE;
      sdo_q <= FILL_BYTE[7];
    end else begin
      if (sample_ev) begin
        sr_q <= {sr_q[6:0], link.far_sdi};
      end
      if (drive_ev) begin
        sdo_q <= sr_q[7];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q <= 3'h0;
      armed_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= link.sck;
      if (!cfg_master && link.ss_n) begin
        bit_cnt_q <= 3'h0;
        armed_q <= 1'b0;
      end else begin
        if (sample_ev) begin
          bit_cnt_q <= bit_cnt_q + 3'h1;
        end
        if (done) begin
          armed_q <= 1'b0;
        end else if (s_load) begin
          armed_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_valid <= 1'b0;
      rx_data <= RST_BYTE;
      busy <= 1'b0;
    end else begin
      rx_valid <= done;
      if (done) begin
        rx_data <= {sr_q[6:0], link.far_sdi};
      end
      busy <= cfg_master ? (state_q != SSP_IDLE) : (bit_cnt_q != 3'h0);
    end
  end

  assign link.far_sck_o = sck_q;
  assign link.far_sck_oe_n = !cfg_master;
  assign link.far_ss_n_o = ss_n_q;
  assign link.far_ss_oe_n = !cfg_master;
  assign link.far_sdo_o = sdo_q;
  assign link.far_sdo_oe_n = !(cfg_master || s_sel);
endmodule : ssp_far

/* logic/ssp_fifo.sv */
`timescale 1ns/100ps
module ssp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_idx_q;
  logic [AW-1:0] rd_idx_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_idx_q];
  assign cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_idx_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_idx_q <= '0;
      rd_idx_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_idx_q <= (wr_idx_q == LAST_IDX) ? '0 : wr_idx_q + 1'b1;
      end
      if (pop) begin
        rd_idx_q <= (rd_idx_q == LAST_IDX) ? '0 : rd_idx_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != FULL_CNT);
      out_valid <= (cnt_d != '0);
    end
  end
endmodule : ssp_fifo

/* logic/ssp_if.sv */
`timescale 1ns/100ps
interface ssp_if;
  logic dev_sck_o;
  logic dev_sck_oe_n;
  logic dev_sdo_o;
  logic dev_sdo_oe_n;
  logic dev_ss_n_o;
  logic dev_ss_oe_n;
  logic far_sck_o;
  logic far_sck_oe_n;
  logic far_sdo_o;
  logic far_sdo_oe_n;
  logic far_ss_n_o;
  logic far_ss_oe_n;
  logic sck;
  logic dev_sdi;
  logic far_sdi;
  logic ss_n;

  // Undriven clock reads low, undriven data and select read high
  assign sck = !dev_sck_oe_n ? dev_sck_o : (!far_sck_oe_n ? far_sck_o : 1'b0);
  assign dev_sdi = !far_sdo_oe_n ? far_sdo_o : 1'b1;
  assign far_sdi = !dev_sdo_oe_n ? dev_sdo_o : 1'b1;
  assign ss_n = !dev_ss_oe_n ? dev_ss_n_o : (!far_ss_oe_n ? far_ss_n_o : 1'b1);

  modport dev (
    output dev_sck_o, dev_sck_oe_n, dev_sdo_o, dev_sdo_oe_n, dev_ss_n_o, dev_ss_oe_n,
    input sck, dev_sdi, ss_n
  );
  modport far (
    output far_sck_o, far_sck_oe_n, far_sdo_o, far_sdo_oe_n, far_ss_n_o, far_ss_oe_n,
    input sck, far_sdi, ss_n
  );
endinterface : ssp_if

/* logic/ssp_pkg.sv */
package ssp_pkg;

  localparam int BYTE_W = 8;

  // Register indices on the device register port
  localparam logic [2:0] REG_BUF = 3'h0;
  localparam logic [2:0] REG_STAT = 3'h1;
  localparam logic [2:0] REG_CTL1 = 3'h2;
  localparam logic [2:0] REG_CTL3 = 3'h3;
  localparam logic [2:0] REG_BAUD = 3'h4;

  localparam int STAT_SMP = 7;
  localparam int STAT_CKE = 6;
  localparam int STAT_BF = 0;
  localparam int CTL1_WRITE_COLLISION_FLAG = 7;
  localparam int CTL1_OV = 6;
  localparam int CTL1_EN = 5;
  localparam int CTL1_CKP = 4;
  localparam int CTL3_BOEN = 4;

  localparam logic [3:0] MODE_M_DIV4 = 4'h0;
  localparam logic [3:0] MODE_M_DIV16 = 4'h1;
  localparam logic [3:0] MODE_M_DIV64 = 4'h2;
  localparam logic [3:0] MODE_M_TMR2 = 4'h3;
  localparam logic [3:0] MODE_S_SS = 4'h4;
  localparam logic [3:0] MODE_S_NOSS = 4'h5;
  localparam logic [3:0] MODE_M_BAUD = 4'ha;

  // Core clocks per half period of the serial clock
  localparam logic [9:0] HALF_DIV4 = 10'h002;
  localparam logic [9:0] HALF_DIV16 = 10'h008;
  localparam logic [9:0] HALF_DIV64 = 10'h020;
  localparam logic [9:0] HALF_BAUD_ADD = 10'h002;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum {SSP_IDLE, SSP_SHIFT} ssp_state_e;

  function automatic logic ssp_lead(input logic prev, input logic now, input logic cpol);
    return (prev == cpol) && (now != cpol);
  endfunction : ssp_lead

  function automatic logic ssp_trail(input logic prev, input logic now, input logic cpol);
    return (prev != cpol) && (now == cpol);
  endfunction : ssp_trail

endpackage : ssp_pkg

/* sim/spi_serial_port_core_tb.sv */
`timescale 1ns/100ps
module spi_serial_port_core_tb;
  import ssp_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic irq_flag_clr = 1'b0;
  logic serial_port_irq_flag;
  logic timer2_tick = 1'b0;
  logic [2:0] tick_cnt = 3'h0;
  logic cfg_master = 1'b0;
  logic far_cke = 1'b1;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_ready;
  logic rx_valid;
  logic [7:0] rx_data;
  logic busy;
  int n_fail = 0;
  int tests_run = 0;
  int n_rx = 0;
  int n_acc = 0;

  ssp_if u_ssp_if ();
  ssp_dev u_ssp_dev (.core_clk(core_clk), .rstn(rstn), .link(u_ssp_if.dev), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq_flag_clr(irq_flag_clr), .serial_port_irq_flag(serial_port_irq_flag),
    .timer2_tick(timer2_tick));
  ssp_far #(.HALF(10'h008), .FIFO_DEPTH(8)) u_ssp_far (.core_clk(core_clk), .rstn(rstn),
    .link(u_ssp_if.far), .cfg_master(cfg_master), .cfg_cpol(1'b0), .cfg_cke(far_cke),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .busy(busy));
  ssp_checker u_ssp_checker (.core_clk(core_clk), .rstn(rstn), .sck(u_ssp_if.sck),
    .ss_n(u_ssp_if.ss_n), .far_sdi(u_ssp_if.far_sdi), .dev_sck_oe_n(u_ssp_if.dev_sck_oe_n),
    .far_sck_oe_n(u_ssp_if.far_sck_oe_n), .dev_ss_oe_n(u_ssp_if.dev_ss_oe_n),
    .far_ss_oe_n(u_ssp_if.far_ss_oe_n), .far_sdo_oe_n(u_ssp_if.far_sdo_oe_n));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // Timer pulse every six cycles, so timer mode gives a six-cycle half period
  always @(negedge core_clk) begin
    tick_cnt <= (tick_cnt == 3'h5) ? 3'h0 : tick_cnt + 3'h1;
    timer2_tick <= (tick_cnt == 3'h5);
  end

  always @(posedge core_clk) begin
    if (rx_valid === 1'b1) n_rx <= n_rx + 1;
  end

  task automatic stop_test();
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd

  task automatic wait_sck(input logic lvl, output int n);
    for (n = 0; n < 300 && u_ssp_if.sck !== lvl; n++) @(negedge core_clk);
  endtask : wait_sck

  task automatic wait_ss_high();
    for (int j = 0; j < 900 && u_ssp_if.ss_n !== 1'b1; j++) @(negedge core_clk);
  endtask : wait_ss_high

  task automatic t_regs();
    logic [7:0] d;
    for (int a = 0; a < 6; a++) begin
      rd(3'(a), d);
      chk("reset value", 8'h00, d);
    end
    wr(REG_STAT, 8'hff);
    rd(REG_STAT, d);
    chk("status", 8'hc0, d);
    wr(REG_CTL1, 8'h5a);
    rd(REG_CTL1, d);
    chk("control one", 8'h5a, d);
    wr(REG_BAUD, 8'h37);
    rd(REG_BAUD, d);
    chk("baud reload", 8'h37, d);
    wr(3'h5, 8'hff);
    rd(3'h5, d);
    chk("unmapped", 8'h00, d);
    wr(REG_CTL1, 8'h00);
    wr(REG_STAT, 8'h40);
  endtask : t_regs

  // Far slave is deselected, so its queue only fills; no byte reaches its shifter
  task automatic t_fill();
    for (int i = 0; i < 12; i++) begin
      @(negedge core_clk);
      tx_valid = tx_ready;
      tx_data = 8'h10 + 8'(n_acc);
      if (tx_ready === 1'b1) n_acc++;
    end
    tx_valid = 1'b0;
    @(negedge core_clk);
    chk("queue accepted", 10'h001, 10'(n_acc == 8 || n_acc == 9));
    chk("queue refuses", 10'h000, tx_ready);
  endtask : t_fill

  task automatic t_dev_master();
    logic [3:0] modes [9] = '{MODE_M_DIV4, MODE_M_DIV16, MODE_M_DIV64, MODE_M_TMR2,
      MODE_M_BAUD, MODE_M_DIV16, MODE_M_DIV16, MODE_M_DIV16, MODE_M_DIV16};
    logic [9:0] halves [9] = '{HALF_DIV4, HALF_DIV16, HALF_DIV64, 10'h006, 10'h00c,
      HALF_DIV16, HALF_DIV16, HALF_DIV16, HALF_DIV16};
    logic [7:0] d;
    logic [7:0] tx;
    logic [7:0] exp;
    int n;
    for (int i = 0; i < 9; i++) begin
      wr(REG_CTL1, 8'h00);
      wr(REG_BAUD, 8'h05);
      wr(REG_CTL1, {4'h2, modes[i]});
      tx = 8'hc3 - 8'(i);
      wr(REG_BUF, tx);
      wr(REG_BUF, 8'hff);
      rd(REG_CTL1, d);
      chk("collision flag", {4'ha, modes[i]}, d);
      wait_sck(1'b0, n);
      wait_sck(1'b1, n);
      wait_sck(1'b0, n);
      chk("sck half period", halves[i], 10'(n));
      for (int j = 0; j < 900 && serial_port_irq_flag !== 1'b1; j++) @(negedge core_clk);
      chk("irq flag", 10'h001, serial_port_irq_flag);
      wait_ss_high();
      rd(REG_STAT, d);
      chk("buffer full", 8'h41, d);
      rd(REG_BUF, d);
      // Fastest rate is only timed: the far slave has no margin there
      // The far slave reloads as soon as a byte ends while still selected, so the
      // preloaded byte is lost at deselect and each frame takes two queue entries
      exp = (2 * i < n_acc) ? 8'h10 + 8'(2 * i) : FILL_BYTE;
      if (i > 0) chk("device rx", exp, d);
      if (i > 0) chk("far rx", tx, rx_data);
      rd(REG_STAT, d);
      chk("buffer full clear", 8'h40, d);
      @(negedge core_clk);
      irq_flag_clr = 1'b1;
      @(negedge core_clk);
      irq_flag_clr = 1'b0;
      @(negedge core_clk);
      chk("irq cleared", 10'h000, serial_port_irq_flag);
    end
    chk("queue drained", 10'h001, tx_ready);
  endtask : t_dev_master

  // Far master sends one byte and the frame is followed to its end
  task automatic far_send(input logic [7:0] b);
    int n0;
    n0 = n_rx;
    tx_valid = 1'b1;
    tx_data = b;
    @(negedge core_clk);
    tx_valid = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("far busy", 10'h001, busy);
    for (int j = 0; j < 900 && n_rx == n0; j++) @(negedge core_clk);
    wait_ss_high();
    @(negedge core_clk);
    chk("far idle", 10'h000, busy);
  endtask : far_send

  task automatic t_dev_slave();
    logic [7:0] d;
    wr(REG_CTL1, 8'h00);
    wr(REG_CTL1, {4'h2, MODE_S_SS});
    wr(REG_BUF, 8'h96);
    @(negedge core_clk);
    cfg_master = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("sdo released", 10'h001, u_ssp_if.dev_sdo_oe_n);
    far_send(8'h69);
    chk("far rx", 8'h96, rx_data);
    chk("slave irq flag", 10'h001, serial_port_irq_flag);
    chk("sdo released after", 10'h001, u_ssp_if.dev_sdo_oe_n);
    // Unselected mode, other phase; the unread byte must survive and the shifter echoes it
    wr(REG_CTL1, {4'h2, MODE_S_NOSS});
    wr(REG_STAT, 8'h00);
    far_cke = 1'b0;
    chk("sdo driven without select", 10'h000, u_ssp_if.dev_sdo_oe_n);
    far_send(8'ha5);
    chk("far rx echo", 8'h69, rx_data);
    rd(REG_BUF, d);
    chk("slave rx", 8'h69, d);
    rd(REG_CTL1, d);
    chk("overflow kept byte", {4'h6, MODE_S_NOSS}, d);
  endtask : t_dev_slave

  initial begin
    #(8 * 30000);
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    t_regs();
    t_fill();
    t_dev_master();
    t_dev_slave();
    stop_test();
  end
endmodule : spi_serial_port_core_tb

/* sim/ssp_checker.sv */
`timescale 1ns/100ps
module ssp_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic far_sdi,
  input wire logic dev_sck_oe_n,
  input wire logic far_sck_oe_n,
  input wire logic dev_ss_oe_n,
  input wire logic far_ss_oe_n,
  input wire logic far_sdo_oe_n
);
  // The bench keeps the link idle low; the stability check only bites in the rising-sample phase
  localparam logic CPOL = 1'b0;
  logic sck_prev_q;
  logic ss_prev_q;
  logic [4:0] tog_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sck_prev_q <= 1'b0;
      ss_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck;
      ss_prev_q <= ss_n;
    end
  end

  // Counts clock toggles of one frame, including a toggle in the deselect cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tog_q <= 5'h00;
    end else if (ss_n && ss_prev_q) begin
      tog_q <= 5'h00;
    end else if (sck != sck_prev_q) begin
      tog_q <= tog_q + 5'h01;
    end
  end

  AST_FAR_SDO_RELEASED: assert property (ss_n && far_ss_oe_n |-> far_sdo_oe_n)
    else $error("far slave drives sdo while deselected");
  AST_SCK_STILL_OUTSIDE: assert property (ss_n && ss_prev_q |-> sck == sck_prev_q)
    else $error("sck moved outside a frame");
  AST_SCK_IDLE_LEVEL: assert property (ss_n && ss_prev_q |-> sck == CPOL)
    else $error("sck not at idle level between frames");
  AST_ONE_CLOCK_DRIVER: assert property (dev_sck_oe_n || far_sck_oe_n)
    else $error("both ends drive sck");
  AST_ONE_SELECT_DRIVER: assert property (dev_ss_oe_n || far_ss_oe_n)
    else $error("both ends drive the select");
  AST_SIXTEEN_EDGES: assert property ($rose(ss_n) |=> tog_q == 5'h10)
    else $error("frame did not carry sixteen clock edges");
  AST_SAMPLE_STABLE: assert property (!ss_n && $rose(sck) |-> $stable(far_sdi))
    else $error("data moved on the sampling edge");
  AST_FRAME_MIN: assert property ($fell(ss_n) |-> !ss_n [*8])
    else $error("frame too short");
  AST_FRAME_BOUND: assert property ($fell(ss_n) |-> ##[1:700] ss_n)
    else $error("frame did not end");
  AST_HALF_MIN: assert property (sck != sck_prev_q |=> sck == sck_prev_q)
    else $error("sck half period below two cycles");
endmodule : ssp_checker
